// ==== design/crc16_rx.sv ====
`timescale 1ns/1ps
// Purpose: serial crc16 over data plus appended crc
// Assumes: one bit per shiftEn, msb first
// Notes: remainder zero means block intact
module crc16_rx import sd_tune_pkg::*; (
  input wire logic ref_clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic clear, // restart at a start bit
  input wire logic shiftEn, // take bitIn
  input wire logic bitIn, // serial data
  output logic crcZero // remainder is zero
);
  logic [CRC_W-1:0] crc;
  wire fb = crc[CRC_W-1] ^ bitIn;
  wire [CRC_W-1:0] next_crc = {crc[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : '0);
  assign crcZero = (crc == '0);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) crc <= '0;
    else if (clear) crc <= '0;
    else if (shiftEn) crc <= next_crc;
  end
endmodule

// ==== design/pin_sync2.sv ====
`timescale 1ns/1ps
// Purpose: two-flop synchroniser for link pins
// Assumes: inputs asynchronous to ref_clk
// Notes: only the second stage leaves the module
module pin_sync2 import sd_tune_pkg::*; #(
  parameter int W = 2
) (
  input wire logic ref_clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic [W-1:0] d, // raw pins
  output logic [W-1:0] q // synchronised pins
);
  logic [W-1:0] s1;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= '0;
      q <= '0;
    end else begin
      s1 <= d;
      q <= s1;
    end
  end
endmodule

// ==== design/sd_tuning_interrupt_gate.sv ====
`timescale 1ns/1ps
// Purpose: tuning sweep with interrupt gating and crc status
// Assumes: card clock and dat0 arrive as pins, sampled on ref_clk
// Notes: crc errors seen while tuning go to the pass map only
module sd_tuning_interrupt_gate import sd_tune_pkg::*; #(
  parameter int NUM_RATIOS = NUM_RATIOS_DEF,
  parameter int BLOCK_BITS = BLOCK_BITS_DEF,
  parameter int TIMEOUT_CYC = TUNE_TIMEOUT_CYC
) (
  input wire logic ref_clk, // 25 MHz system clock
  input wire logic rst_n, // async reset, active low
  input wire logic [7:0] addr, // register byte address
  input wire logic [31:0] wrData, // write data
  input wire logic wrEn, // write strobe
  input wire logic rdEn, // read strobe
  output logic [31:0] rdData, // read data, cycle after rdEn
  input wire logic sdClkPin, // card bus clock
  input wire logic dat0Pin, // card data line 0
  output logic sendCmd, // one-cycle command request
  output logic [5:0] cmdIndex, // command to send
  output logic hostIntReq // gated interrupt request
);
  localparam int RATIO_W = $clog2(NUM_RATIOS);
  localparam int TOTAL_BITS = BLOCK_BITS + CRC_W;
  localparam int CNT_W = $clog2(TOTAL_BITS + 1);

  // -------------------------------------------------------------
  // parameter checks
  // -------------------------------------------------------------
  if (NUM_RATIOS < 2 || NUM_RATIOS > 32 || (1 << RATIO_W) != NUM_RATIOS) begin : g_badRatios
    $error("NUM_RATIOS must be a power of two from 2 to 32");
  end
  if (BLOCK_BITS < 1) begin : g_badBlock
    $error("BLOCK_BITS must be positive");
  end
  if (TIMEOUT_CYC < 1 || TIMEOUT_CYC > 65535) begin : g_badTmo
    $error("TIMEOUT_CYC must fit 16 bits");
  end

  // -------------------------------------------------------------
  // pin sampling and delay line
  // -------------------------------------------------------------
  logic [1:0] syncPins;
  logic sdClkPrev;
  logic [NUM_RATIOS-1:0] hist;
  logic executeTuning;
  logic [RATIO_W-1:0] tryRatio;
  logic [RATIO_W-1:0] selRatio;

  pin_sync2 #(.W(2)) uSync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .d({sdClkPin, dat0Pin}),
    .q(syncPins)
  );

  wire sdRise = syncPins[1] & ~sdClkPrev;
  wire [RATIO_W-1:0] activeRatio = executeTuning ? tryRatio : selRatio;
  // the tap chosen by the ratio stands in for the dll-delayed sample clock
  wire delayedBit = hist[activeRatio];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) sdClkPrev <= 1'b0;
    else sdClkPrev <= syncPins[1];
  end

  // tap spacing is one ref_clk period; finer steps need a real delay line
  genvar g;
  for (g = 0; g < NUM_RATIOS; g++) begin : g_tap
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) hist[g] <= 1'b0;
      else if (g == 0) hist[g] <= syncPins[0];
      else hist[g] <= hist[(g == 0) ? 0 : g - 1];
    end
  end

  // -------------------------------------------------------------
  // block receiver
  // -------------------------------------------------------------
  logic rxBusy;
  logic [CNT_W-1:0] bitCnt;
  logic rxFinish;
  logic crcZero;
  logic rxForTune;

  wire rxStart = sdRise & ~rxBusy & ~delayedBit;
  wire rxShift = sdRise & rxBusy;
  wire rxLast = rxShift & (bitCnt == CNT_W'(TOTAL_BITS - 1));
  wire blockDone = rxFinish;
  wire crcBad = ~crcZero;

  crc16_rx uCrc (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clear(rxStart),
    .shiftEn(rxShift),
    .bitIn(delayedBit),
    .crcZero(crcZero)
  );

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxBusy <= 1'b0;
      bitCnt <= '0;
      rxFinish <= 1'b0;
      rxForTune <= 1'b0;
    end else begin
      rxFinish <= rxLast;
      if (rxStart) begin
        rxBusy <= 1'b1;
        bitCnt <= '0;
        rxForTune <= executeTuning;
      end else if (rxShift) begin
        rxBusy <= ~rxLast;
        bitCnt <= bitCnt + 1'b1;
      end
    end
  end

  // -------------------------------------------------------------
  // register decode
  // -------------------------------------------------------------
  wire ctrlWr = wrEn & (addr == OFS_CTRL);
  wire stsWr = wrEn & (addr == OFS_STATUS);
  wire enWr = wrEn & (addr == OFS_ENABLE);
  wire startReq = ctrlWr & wrData[BIT_EXEC];
  wire abortReq = ctrlWr & ~wrData[BIT_EXEC];

  // -------------------------------------------------------------
  // tuning sweep
  // -------------------------------------------------------------
  tune_state_t tuneState;
  logic [NUM_RATIOS-1:0] passMap;
  logic [15:0] tmoCnt;
  logic tuned;
  logic tuneFail;

  function automatic logic [RATIO_W-1:0] firstPass(input logic [NUM_RATIOS-1:0] m);
    logic [RATIO_W-1:0] r;
    r = '0;
    for (int i = NUM_RATIOS - 1; i >= 0; i--) begin
      if (m[i]) r = RATIO_W'(i);
    end
    return r;
  endfunction

  wire tmoHit = (tmoCnt == 16'(TIMEOUT_CYC - 1));
  wire stepDone = (tuneState == T_WAIT) & (blockDone | tmoHit);
  wire lastRatio = (tryRatio == RATIO_W'(NUM_RATIOS - 1));
  wire ratioPass = blockDone & ~crcBad;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tuneState <= T_IDLE;
      tryRatio <= '0;
      selRatio <= '0;
      passMap <= '0;
      tmoCnt <= '0;
      executeTuning <= 1'b0;
      tuned <= 1'b0;
      tuneFail <= 1'b0;
    end else if (abortReq && tuneState != T_IDLE) begin
      tuneState <= T_IDLE;
      executeTuning <= 1'b0;
    end else begin
      tmoCnt <= (tuneState == T_WAIT) ? tmoCnt + 1'b1 : '0;
      case (tuneState)
        T_IDLE: begin
          if (startReq) begin
            tuneState <= T_SEND;
            tryRatio <= '0;
            passMap <= '0;
            executeTuning <= 1'b1;
            tuned <= 1'b0;
            tuneFail <= 1'b0;
          end
        end
        T_SEND: tuneState <= T_WAIT;
        T_WAIT: begin
          if (stepDone) begin
            passMap[tryRatio] <= ratioPass;
            tuneState <= lastRatio ? T_END : T_SEND;
            if (!lastRatio) tryRatio <= tryRatio + 1'b1;
          end
        end
        T_END: begin
          // tuning end follows the final step by two cycles; after a ratio timeout the block may still be in flight
          executeTuning <= 1'b0;
          selRatio <= firstPass(passMap);
          tuned <= (passMap != '0);
          tuneFail <= (passMap == '0);
          tuneState <= T_IDLE;
        end
        default: tuneState <= T_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sendCmd <= 1'b0;
      cmdIndex <= '0;
    end else begin
      sendCmd <= (tuneState == T_SEND);
      cmdIndex <= CMD_TUNING;
    end
  end

  // -------------------------------------------------------------
  // status, enable and interrupt gate
  // -------------------------------------------------------------
  logic stsCrcErr;
  logic stsRdReady;
  logic enCrcErr;
  logic enRdReady;

  // a block begun or ended while tuning never sets crc status, last ratio included;
  // a block cut off by the ratio timeout may end after tuning is over
  wire crcErrSet = blockDone & crcBad & ~executeTuning & ~rxForTune;
  wire rdReadySet = blockDone & (executeTuning | ~crcBad);
  wire crcErrClr = stsWr & wrData[BIT_CRC_ERR];
  wire rdReadyClr = stsWr & wrData[BIT_RD_READY];
  wire rdReadyPend = stsRdReady & enRdReady;
  wire crcErrPend = stsCrcErr & enCrcErr;
  wire next_int = executeTuning ? rdReadyPend : (rdReadyPend | crcErrPend);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stsCrcErr <= 1'b0;
      stsRdReady <= 1'b0;
      enCrcErr <= RST_ENABLE_BIT;
      enRdReady <= RST_ENABLE_BIT;
      hostIntReq <= 1'b0;
    end else begin
      // set wins over a clear landing in the same cycle
      stsCrcErr <= crcErrSet | (stsCrcErr & ~crcErrClr);
      stsRdReady <= rdReadySet | (stsRdReady & ~rdReadyClr);
      if (enWr) begin
        enCrcErr <= wrData[BIT_CRC_ERR];
        enRdReady <= wrData[BIT_RD_READY];
      end
      hostIntReq <= next_int;
    end
  end

  // -------------------------------------------------------------
  // read path
  // -------------------------------------------------------------
  logic [31:0] ctrlWord;
  logic [31:0] stsWord;
  logic [31:0] enWord;
  logic [31:0] tuneWord;
  logic [31:0] mapWord;

  always_comb begin
    ctrlWord = '0;
    stsWord = '0;
    enWord = '0;
    tuneWord = '0;
    mapWord = '0;
    ctrlWord[BIT_EXEC] = executeTuning;
    ctrlWord[BIT_TUNED] = tuned;
    ctrlWord[BIT_TFAIL] = tuneFail;
    stsWord[BIT_CRC_ERR] = stsCrcErr;
    stsWord[BIT_RD_READY] = stsRdReady;
    enWord[BIT_CRC_ERR] = enCrcErr;
    enWord[BIT_RD_READY] = enRdReady;
    tuneWord[TUNE_SEL_LSB +: RATIO_W] = selRatio;
    tuneWord[TUNE_TRY_LSB +: RATIO_W] = tryRatio;
    mapWord[NUM_RATIOS-1:0] = passMap;
  end

  wire [31:0] rdMux = (addr == OFS_CTRL) ? ctrlWord :
                      (addr == OFS_STATUS) ? stsWord :
                      (addr == OFS_ENABLE) ? enWord :
                      (addr == OFS_TUNE) ? tuneWord :
                      (addr == OFS_PASSMAP) ? mapWord : RD_IDLE;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) rdData <= RD_IDLE;
    else rdData <= rdEn ? rdMux : RD_IDLE;
  end

  // -------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_finalBlock;
    (tuneState == T_WAIT) && stepDone && lastRatio && !abortReq;
  endsequence
  sequence s_tuneClose;
    (tuneState == T_END) ##1 (!executeTuning && tuneState == T_IDLE);
  endsequence

  property p_dllTap;
    sdRise && !rxBusy && !hist[activeRatio] |=> rxBusy && bitCnt == '0;
  endproperty
  a_dllTap: assert property (p_dllTap) else $error("start not taken from tap");

  property p_cmd19;
    (tuneState == T_SEND) |=> sendCmd && cmdIndex == 6'h13 ##1 !sendCmd;
  endproperty
  a_cmd19: assert property (p_cmd19) else $error("tuning command not issued");

  property p_gate;
    executeTuning |=> hostIntReq == $past(stsRdReady && enRdReady);
  endproperty
  a_gate: assert property (p_gate) else $error("interrupt escaped tuning gate");

  property p_crcErrSet;
    blockDone && crcBad && !executeTuning && !rxForTune |=> stsCrcErr;
  endproperty
  a_crcErrSet: assert property (p_crcErrSet) else $error("crc error not reported");

  property p_lastMasked;
    s_finalBlock |=> ($stable(stsCrcErr) || $past(crcErrClr)) [*2];
  endproperty
  a_lastMasked: assert property (p_lastMasked) else $error("last block crc escaped");

  property p_endOrder;
    s_finalBlock |=> s_tuneClose;
  endproperty
  a_endOrder: assert property (p_endOrder) else $error("tuning end out of order");

  property p_mask;
    !enCrcErr && !(stsRdReady && enRdReady) |=> !hostIntReq;
  endproperty
  a_mask: assert property (p_mask) else $error("masked crc interrupt raised");

  property p_sticky;
    stsCrcErr && !crcErrClr |=> stsCrcErr;
  endproperty
  a_sticky: assert property (p_sticky) else $error("crc status lost");

  property p_w1c;
    stsCrcErr && crcErrClr && !crcErrSet |=> !stsCrcErr;
  endproperty
  a_w1c: assert property (p_w1c) else $error("crc status not cleared");
endmodule

// ==== shared/sd_tune_pkg.sv ====
// Purpose: constants and types for the sampling-clock tuning gate
// Assumes: 25 MHz ref_clk, byte-addressed 32-bit register port
// Notes: offsets are byte addresses, one word per register
// Function
// - dll delays the card data sampling clock
// - tuning runs on cmd19, one ratio each
// - during execute_tuning only block read ready interrupts
// - data crc failure sets status bit 21
// - last tuning block crc failure stays masked
// - crc report no later than tuning end; code never sets crc status for a block begun or ended while tuning
// - enable bit 21 low masks crc interrupt
package sd_tune_pkg;
  // -------------------------------------------------------------
  // register map
  // -------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_ENABLE = 8'h08;
  localparam logic [7:0] OFS_TUNE = 8'h0C;
  localparam logic [7:0] OFS_PASSMAP = 8'h10;
  localparam int BIT_EXEC = 0;
  localparam int BIT_TUNED = 1;
  localparam int BIT_TFAIL = 2;
  localparam int BIT_RD_READY = 5;
  localparam int BIT_CRC_ERR = 21;
  localparam int TUNE_SEL_LSB = 0;
  localparam int TUNE_TRY_LSB = 8;
  localparam logic RST_ENABLE_BIT = 1'b0;
  localparam logic [31:0] RD_IDLE = 32'h0000_0000;
  // -------------------------------------------------------------
  // link and timing
  // -------------------------------------------------------------
  localparam logic [5:0] CMD_TUNING = 6'h13;
  localparam int CRC_W = 16;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam int NUM_RATIOS_DEF = 16;
  localparam int BLOCK_BITS_DEF = 512;
  localparam int CLK_MHZ = 25;
  localparam int TUNE_TIMEOUT_US = 200;
  localparam int TUNE_TIMEOUT_CYC = TUNE_TIMEOUT_US * CLK_MHZ;
  typedef enum {T_IDLE, T_SEND, T_WAIT, T_END} tune_state_t;
endpackage

// ==== sim/sd_card_model.sv ====
`timescale 1ns/1ps
// Purpose: behavioural card that answers tuning commands with one data block
// Assumes: block is start bit, data, crc16 msb first, end bit
// Notes: clock stands still and data line idles high between frames
module sd_card_model import sd_tune_pkg::*; #(
  parameter int BITS = 16
) (
  input wire logic ref_clk, // system clock, used to see requests
  input wire logic sendCmd, // command request from the host
  input wire logic [5:0] cmdIndex, // command number
  input wire logic kick, // bench asks for an unsolicited block
  input wire logic kickBad, // corrupt the unsolicited block
  input wire logic [3:0] badMask, // corrupt crc of tuning block n mod 4
  output logic sdClk, // card bus clock
  output logic dat0 // data line 0
);
  int blk = 0;
  int tunePend = 0;
  int kickPend = 0;
  logic kickBadQ = 1'b0;
  initial begin
    sdClk = 1'b0;
    dat0 = 1'b1;
  end
  // -------------------------------------------------------------
  // frame generator
  // -------------------------------------------------------------
  task automatic send_block(input logic bad);
    logic [15:0] crc;
    logic [BITS+16:0] fr;
    logic b;
    crc = 16'h0000;
    fr[BITS+16] = 1'b0;
    for (int i = BITS - 1; i >= 0; i--) begin
      b = 1'($urandom_range(1, 0));
      fr[16+i] = b;
      crc = {crc[14:0], 1'b0} ^ ((b ^ crc[15]) ? CRC_POLY : 16'h0000);
    end
    // a bad block flips only the last crc bit, the hardest case to catch
    fr[15:0] = bad ? (crc ^ 16'h0001) : crc;
    for (int i = BITS + 16; i >= -1; i--) begin
      dat0 = (i >= 0) ? fr[i] : 1'b1;
      #160 sdClk = 1'b1;
      #160 sdClk = 1'b0;
    end
    dat0 = 1'b1; // idle: the model drives the line high
  endtask
  // requests are queued: the next command comes while the end bit is still out
  always @(posedge ref_clk) begin
    if (sendCmd === 1'b1 && cmdIndex === CMD_TUNING) tunePend++;
    if (kick === 1'b1) begin
      kickPend++;
      kickBadQ = kickBad;
    end
  end
  // replies start 10 ns off the ref_clk edge; each queued reply lands 10 ns later, so the fourth in a row starts on an edge
  initial begin
    forever begin
      wait (tunePend > 0 || kickPend > 0);
      #410;
      if (tunePend > 0) begin
        tunePend--;
        send_block(badMask[blk%4]);
        blk++;
      end else begin
        kickPend--;
        send_block(kickBadQ);
      end
    end
  end
endmodule

// ==== sim/sd_tuning_interrupt_gate_tb.sv ====
`timescale 1ns/1ps
// Purpose: self-checking bench for the tuning interrupt gate
// Assumes: card model answers each tuning command with one block
// Notes: short blocks and four ratios keep the run brief
module sd_tuning_interrupt_gate_tb;
  import sd_tune_pkg::*;
  localparam int NR = 4;
  localparam int BB = 16;
  localparam logic [31:0] ERR_MASK = 32'h0020_0000;
  localparam logic [31:0] RDY_MASK = 32'h0000_0020;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wrEn = 1'b0;
  logic rdEn = 1'b0;
  logic kick = 1'b0;
  logic kickBad = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wrData = 32'h0;
  logic [31:0] rdData, got, d;
  logic [3:0] badMask = 4'h0;
  logic sdClk, dat0, sendCmd, hostIntReq, quiet, leak;
  logic [5:0] cmdIndex;
  logic [31:0] expStatus = 32'h0;
  logic [31:0] expEnable = 32'h0;
  int num_errors = 0;
  int comparisons = 0;
  int cmdCount = 0;
  logic [7:0] resetRegs [5] = '{OFS_CTRL, OFS_STATUS, OFS_ENABLE, OFS_PASSMAP, 8'h14};

  sd_tuning_interrupt_gate #(.NUM_RATIOS(NR), .BLOCK_BITS(BB), .TIMEOUT_CYC(600)) uut (
    .ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wrData(wrData), .wrEn(wrEn),
    .rdEn(rdEn), .rdData(rdData), .sdClkPin(sdClk), .dat0Pin(dat0), .sendCmd(sendCmd),
    .cmdIndex(cmdIndex), .hostIntReq(hostIntReq));
  sd_card_model #(.BITS(BB)) card (.ref_clk(ref_clk), .sendCmd(sendCmd),
    .cmdIndex(cmdIndex), .kick(kick), .kickBad(kickBad), .badMask(badMask),
    .sdClk(sdClk), .dat0(dat0));

  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  // quiet marks spans where no interrupt may leave the block
  always @(posedge ref_clk) begin
    if (sendCmd === 1'b1 && cmdIndex === CMD_TUNING) cmdCount++;
    if (quiet === 1'b1 && hostIntReq !== 1'b0) leak = 1'b1;
  end
  // -------------------------------------------------------------
  // bus and compare tasks
  // -------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    addr <= a;
    wrData <= v;
    wrEn <= 1'b1;
    @(posedge ref_clk);
    wrEn <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge ref_clk);
    rdEn <= 1'b0;
    #1 got = rdData;
  endtask
  task automatic settle;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t ns: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    chk_word({31'h0, g}, {31'h0, e});
  endtask
  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task automatic sweep(input logic [3:0] mask, input logic [31:0] en, input logic q);
    int pass;
    int sel;
    pass = ~mask & 4'hF;
    sel = 0;
    for (int i = NR - 1; i >= 0; i--) if (pass[i]) sel = i;
    wr(OFS_STATUS, 32'hFFFF_FFFF);
    expEnable = en;
    wr(OFS_ENABLE, en);
    badMask <= mask;
    cmdCount = 0;
    leak = 1'b0;
    quiet = q;
    wr(OFS_CTRL, 32'h0000_0001);
    for (int k = 0; k < 60; k++) begin
      repeat (50) @(posedge ref_clk);
      rd(OFS_CTRL);
      if (got[BIT_EXEC] === 1'b0) break;
    end
    settle;
    quiet = 1'b0;
    expStatus = RDY_MASK;
    chk_word(cmdCount, NR);
    chk_bit(leak, 1'b0);
    rd(OFS_CTRL);
    chk_word(got, {29'h0, pass == 0, pass != 0, 1'b0});
    rd(OFS_PASSMAP);
    chk_word(got, pass);
    rd(OFS_TUNE);
    chk_word(got & 32'h0000_000F, sel);
    rd(OFS_STATUS);
    chk_word(got, expStatus);
    chk_bit(hostIntReq, |(expStatus & expEnable));
    $display("sweep with bad mask %h done", mask);
  endtask
  task automatic loose_block(input logic bad, input logic [31:0] en);
    wr(OFS_STATUS, 32'hFFFF_FFFF);
    expEnable = en;
    wr(OFS_ENABLE, en);
    @(posedge ref_clk);
    kickBad <= bad;
    kick <= 1'b1;
    @(posedge ref_clk);
    kick <= 1'b0;
    for (int k = 0; k < 40; k++) begin
      repeat (20) @(posedge ref_clk);
      rd(OFS_STATUS);
      if (got !== 32'h0) break;
    end
    expStatus = bad ? ERR_MASK : RDY_MASK;
    chk_word(got, expStatus);
    settle;
    chk_bit(hostIntReq, |(expStatus & expEnable));
  endtask

  initial begin
    void'($urandom(32'hDB9DC10F));
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    foreach (resetRegs[i]) begin
      rd(resetRegs[i]);
      chk_word(got, 32'h0);
    end
    chk_word({26'h0, cmdIndex}, {26'h0, CMD_TUNING});
    chk_bit(hostIntReq, 1'b0);
    $display("reset values done");
    sweep(4'h8, ERR_MASK, 1'b1);
    sweep(4'hB, ERR_MASK | RDY_MASK, 1'b0);
    sweep(4'hF, 32'h0, 1'b1);
    loose_block(1'b1, 32'h0);
    wr(OFS_STATUS, ~ERR_MASK);
    rd(OFS_STATUS);
    chk_word(got, expStatus);
    expEnable = ERR_MASK;
    wr(OFS_ENABLE, ERR_MASK);
    settle;
    chk_bit(hostIntReq, 1'b1);
    wr(OFS_STATUS, ERR_MASK);
    expStatus = 32'h0;
    settle;
    chk_bit(hostIntReq, 1'b0);
    rd(OFS_STATUS);
    chk_word(got, expStatus);
    loose_block(1'b0, RDY_MASK);
    wr(OFS_STATUS, RDY_MASK);
    $display("blocks outside tuning done");
    for (int k = 0; k < 4; k++) begin
      d = $urandom;
      wr(OFS_PASSMAP, d);
      wr(8'h24, d);
      wr(OFS_ENABLE, d);
      rd(OFS_PASSMAP);
      chk_word(got, 32'h0);
      rd(8'h24);
      chk_word(got, 32'h0);
      rd(OFS_ENABLE);
      chk_word(got & (ERR_MASK | RDY_MASK), d & (ERR_MASK | RDY_MASK));
    end
    $display("random register access done");
    report_and_stop;
  end
  initial begin
    repeat (30000) @(posedge ref_clk);
    num_errors++;
    report_and_stop;
  end
endmodule
